// File: hw/sfb_front_end.sv
// serial bus front end: framing, hold, dual pins, status register and busy timing
`timescale 1ns/1ns
// Contract
// [RULE1] Selection and command intake start only on a falling select edge.
// [RULE2] Select high deselects the device and holds it in standby.
// [RULE3] Host keeps select low for the whole command sequence.
// [RULE4] Input bits captured on rising clock, output bits launched after falling clock.
// [RULE5] Clock modes 0 and 3 both work; sampling edges are the same.
// [RULE6] Dual mode uses both data pins with the same edge discipline.
// [RULE7] Hold falling while clock low pauses; bit position is kept.
// [RULE8] Hold rising while clock low resumes the paused sequence.
// [RULE9] Host changes hold only while the clock is low.
// [RULE10] During hold the output floats and clock and data are ignored.
// [RULE11] Select rising during hold abandons the sequence and returns to standby.
// [RULE12] Pause lasts while hold stays low; resume needs hold high, select low.
// [RULE13] Status write refused only when protect pin low and lock bit set.
// [RULE14] Guard and lock bits protect the array and the status register.
// [RULE15] Host only polls status while a program or erase runs.
// [RULE16] Status bit 0 is read-only busy, zero after power-up.
// [RULE17] Status bit 1 is read-only write-enable latch, zero after power-up.
// [RULE18] Status bits 2 to 4 are writable guard level bits.
// [RULE19] Status bit 5 puts the guarded region at bottom when set.
// [RULE20] Array is 128 sectors of 4 KB inside eight 64 KB blocks.
// [RULE21] Busy lasts 250 ms chip, 40 ms sector, 80 ms block erase.
// [RULE22] Page program takes up to one page and keeps busy 4 ms.
// [RULE23] Latch clears at power-up and after disable, program, erase, status write; code keeps it set after a program that writes no byte.
// [RULE24] Protect pin low with lock set freezes guard, bottom and lock bits.
// [RULE25] Levels 1-3 guard an eighth, quarter, half; level 0 none; bit 2 all.
// [RULE26] Chip erase runs only with all guard bits and bottom bit zero.
// [RULE27] Output floats when deselected or not shifting read data.
module sfb_front_end #(
  parameter int unsigned CHIP_ERASE_CYC = sfb_pkg::CHIP_ERASE_CYC,
  parameter int unsigned SECTOR_ERASE_CYC = sfb_pkg::SECTOR_ERASE_CYC,
  parameter int unsigned BLOCK_ERASE_CYC = sfb_pkg::BLOCK_ERASE_CYC,
  parameter int unsigned PAGE_PROG_CYC = sfb_pkg::PAGE_PROG_CYC
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_hold_n,
  input wire logic i_wp_n,
  input wire logic [1:0] i_dual_data_pins,
  output logic [1:0] o_dual_data_pins,
  output logic [1:0] o_dual_data_pins_oe,
  output logic [18:0] o_read_addr,
  input wire logic [7:0] i_read_data,
  output logic o_prog_valid,
  output logic [18:0] o_prog_addr,
  output logic [7:0] o_prog_data,
  output logic o_erase_valid,
  output logic [1:0] o_erase_kind,
  output logic [18:0] o_erase_addr,
  output logic [7:0] o_status
);
  sfb_pins_if pins();

  sfb_pkg::sfb_state_t state;
  sfb_pkg::sfb_addr_t addr;
  sfb_pkg::sfb_timer_t timer;
  logic selected;
  logic held;
  logic busy;
  logic write_enable_latch;
  logic bottom;
  logic lock;
  logic wr_have;
  logic prog_any;
  logic drive_en;
  logic [2:0] level;
  logic [2:0] bitcnt;
  logic [2:0] step;
  logic [2:0] out_cnt;
  logic [2:0] out_step;
  logic [1:0] addr_bytes;
  logic [7:0] opcode;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [7:0] wr_byte;
  logic [7:0] out_byte;
  logic [7:0] out_src;
  logic [7:0] out_cur;
  logic [7:0] status;
  logic rise_ok;
  logic fall_ok;
  logic byte_done;
  logic out_wrap;
  logic frame_end;
  logic dual_io;
  logic lock_on;
  logic may_write;
  logic addr_guarded;

  sfb_pin_sync u_sync (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_cs_n(i_cs_n),
    .i_sck(i_sck),
    .i_hold_n(i_hold_n),
    .i_wp_n(i_wp_n),
    .i_din(i_dual_data_pins),
    .pins(pins.sync)
  );

  // edge qualification: clock and data are ignored while paused
  assign rise_ok = pins.sck_rise & selected & ~held; // [RULE4] [RULE10]
  assign fall_ok = pins.sck_fall & selected & ~held; // [RULE4] [RULE10]
  assign dual_io = opcode == sfb_pkg::OP_DUAL_IO_READ;
  assign step = (dual_io && (state == sfb_pkg::ST_ADDR || state == sfb_pkg::ST_DUMMY)) ? 3'h2 : 3'h1; // [RULE6]
  assign next_shreg = (step == 3'h2) ? {shreg[5:0], pins.din} : {shreg[6:0], pins.din[0]}; // [RULE6]
  assign byte_done = rise_ok & (3'(bitcnt + step) == 3'h0);
  // a command only executes when select rises on a byte boundary, not paused
  assign frame_end = pins.cs_rise & selected & ~held & (bitcnt == 3'h0); // [RULE3] [RULE11]
  assign lock_on = ~pins.wp_n & lock; // [RULE13]
  assign may_write = write_enable_latch & ~busy; // [RULE15]
  assign addr_guarded = sfb_pkg::sfb_guarded(level, bottom, addr[sfb_pkg::ADDR_W-1:sfb_pkg::BLOCK_LSB]); // [RULE20]

  // status image; bit 6 reads zero
  always_comb begin
    status = 8'h00;
    status[sfb_pkg::ST_BUSY] = busy; // [RULE16]
    status[sfb_pkg::ST_WEL] = write_enable_latch; // [RULE17]
    status[sfb_pkg::ST_GL2:sfb_pkg::ST_GL0] = level; // [RULE18]
    status[sfb_pkg::ST_BOTTOM] = bottom; // [RULE19]
    status[sfb_pkg::ST_LOCK] = lock;
  end
  assign o_status = status;
  assign o_read_addr = addr;

  // read path byte source and lane width
  assign out_step = dual_io ? 3'h2 : 3'h1; // [RULE6]
  assign out_src = (opcode == sfb_pkg::OP_READ_STATUS) ? status : i_read_data;
  assign out_cur = (out_cnt == 3'h0) ? out_src : out_byte;
  assign out_wrap = fall_ok & (3'(out_cnt + out_step) == 3'h0);

  // selection follows the select pin
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      selected <= 1'b0;
    end else if (pins.cs_n) begin
      selected <= 1'b0; // [RULE2]
    end else if (pins.cs_fall) begin
      selected <= 1'b1; // [RULE1]
    end
  end

  // hold pause, only recognised while the clock is low
  always_ff @(posedge i_clk) begin
    if (i_srst || !selected) begin
      held <= 1'b0; // [RULE11]
    end else if (!pins.sck) begin // [RULE9]
      if (pins.hold_fall) begin
        held <= 1'b1; // [RULE7] [RULE12]
      end else if (pins.hold_rise) begin
        held <= 1'b0; // [RULE8] [RULE12]
      end
    end
  end

  // command sequencer
  always_ff @(posedge i_clk) begin
    if (i_srst || pins.cs_n) begin
      state <= sfb_pkg::ST_IDLE; // [RULE2] [RULE11]
      addr_bytes <= 2'h0;
      if (i_srst) begin
        opcode <= 8'h00;
      end
    end else if (pins.cs_fall) begin
      state <= sfb_pkg::ST_OPC; // [RULE1]
      addr_bytes <= 2'h0;
    end else if (byte_done) begin
      case (state)
        sfb_pkg::ST_OPC: begin
          opcode <= next_shreg;
          case (next_shreg)
            sfb_pkg::OP_READ, sfb_pkg::OP_DUAL_IO_READ, sfb_pkg::OP_PAGE_PROG, sfb_pkg::OP_SECTOR_ERASE,
            sfb_pkg::OP_SECTOR_ERASE_ALT, sfb_pkg::OP_BLOCK_ERASE: begin
              state <= sfb_pkg::ST_ADDR;
            end
            sfb_pkg::OP_READ_STATUS: begin
              state <= sfb_pkg::ST_RDATA;
            end
            sfb_pkg::STATUS_WRITE_CMD: begin
              state <= sfb_pkg::ST_WDATA;
            end
            default: begin
              state <= sfb_pkg::ST_SKIP;
            end
          endcase
        end
        sfb_pkg::ST_ADDR: begin
          addr_bytes <= 2'(addr_bytes + 2'h1);
          if (addr_bytes == sfb_pkg::ADDR_LAST) begin
            case (opcode)
              sfb_pkg::OP_READ: state <= sfb_pkg::ST_RDATA;
              sfb_pkg::OP_DUAL_IO_READ: state <= sfb_pkg::ST_DUMMY;
              sfb_pkg::OP_PAGE_PROG: state <= sfb_pkg::ST_WDATA;
              default: state <= sfb_pkg::ST_SKIP;
            endcase
          end
        end
        sfb_pkg::ST_DUMMY: begin
          state <= sfb_pkg::ST_RDATA;
        end
        default: begin
        end
      endcase
    end
  end

  // input shifter; the bit position survives a pause
  always_ff @(posedge i_clk) begin
    if (i_srst || !selected) begin
      shreg <= 8'h00;
      bitcnt <= 3'h0;
    end else if (rise_ok) begin
      shreg <= next_shreg; // [RULE4] [RULE7]
      bitcnt <= 3'(bitcnt + step);
    end
  end

  // address: loaded msb first, wraps in page on program, steps on read
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      addr <= '0;
    end else if (byte_done && state == sfb_pkg::ST_ADDR) begin
      addr <= {addr[sfb_pkg::ADDR_W-9:0], next_shreg};
    end else if (byte_done && state == sfb_pkg::ST_WDATA && opcode == sfb_pkg::OP_PAGE_PROG) begin
      addr[7:0] <= 8'(addr[7:0] + 8'h01); // [RULE22]
    end else if (out_wrap && opcode != sfb_pkg::OP_READ_STATUS) begin
      addr <= sfb_pkg::sfb_addr_t'(addr + 1'b1);
    end
  end

  // status write data: first byte only
  always_ff @(posedge i_clk) begin
    if (i_srst || !selected) begin
      wr_byte <= 8'h00;
      wr_have <= 1'b0;
    end else if (byte_done && state == sfb_pkg::ST_WDATA && opcode == sfb_pkg::STATUS_WRITE_CMD && !wr_have) begin
      wr_byte <= next_shreg;
      wr_have <= 1'b1;
    end
  end

  // program bytes go to the array as they arrive, unless guarded
  always_ff @(posedge i_clk) begin
    o_prog_valid <= 1'b0;
    if (i_srst) begin
      prog_any <= 1'b0;
      o_prog_addr <= '0;
      o_prog_data <= 8'h00;
    end else if (!selected) begin
      prog_any <= 1'b0;
    end else if (byte_done && state == sfb_pkg::ST_WDATA && opcode == sfb_pkg::OP_PAGE_PROG &&
                 may_write && !addr_guarded) begin // [RULE14] [RULE25]
      o_prog_valid <= 1'b1;
      o_prog_addr <= addr;
      o_prog_data <= next_shreg;
      prog_any <= 1'b1;
    end
  end

  // command execution, write latch, guard bits and busy timer
  always_ff @(posedge i_clk) begin
    o_erase_valid <= 1'b0;
    if (i_srst) begin
      busy <= 1'b0; // [RULE16]
      timer <= '0;
      write_enable_latch <= 1'b0; // [RULE17] [RULE23]
      level <= sfb_pkg::GUARD_LEVEL_RST;
      bottom <= sfb_pkg::GUARD_AT_BOTTOM_RST;
      lock <= sfb_pkg::GUARD_LOCK_RST;
      o_erase_kind <= sfb_pkg::ERASE_SECTOR;
      o_erase_addr <= '0;
    end else begin
      if (busy) begin
        timer <= sfb_pkg::sfb_timer_t'(timer - 1'b1);
        if (timer == sfb_pkg::sfb_timer_t'(1)) begin
          busy <= 1'b0;
        end
      end
      if (frame_end) begin
        case (opcode)
          sfb_pkg::OP_WRITE_ENABLE: begin
            if (state == sfb_pkg::ST_SKIP && !busy) begin
              write_enable_latch <= 1'b1;
            end
          end
          sfb_pkg::WRITE_DISABLE_CMD: begin
            if (state == sfb_pkg::ST_SKIP) begin
              write_enable_latch <= 1'b0; // [RULE23]
            end
          end
          sfb_pkg::STATUS_WRITE_CMD: begin
            if (state == sfb_pkg::ST_WDATA && wr_have && may_write) begin
              write_enable_latch <= 1'b0; // [RULE23]
              if (!lock_on) begin // [RULE13] [RULE24]
                level <= wr_byte[sfb_pkg::ST_GL2:sfb_pkg::ST_GL0]; // [RULE18]
                bottom <= wr_byte[sfb_pkg::ST_BOTTOM]; // [RULE19]
                lock <= wr_byte[sfb_pkg::ST_LOCK]; // [RULE14]
              end
            end
          end
          sfb_pkg::OP_PAGE_PROG: begin
            if (state == sfb_pkg::ST_WDATA && prog_any) begin
              write_enable_latch <= 1'b0; // [RULE23]
              busy <= 1'b1;
              timer <= sfb_pkg::sfb_timer_t'(PAGE_PROG_CYC); // [RULE22]
            end
          end
          sfb_pkg::OP_SECTOR_ERASE, sfb_pkg::OP_SECTOR_ERASE_ALT, sfb_pkg::OP_BLOCK_ERASE: begin
            if (state == sfb_pkg::ST_SKIP && may_write) begin
              write_enable_latch <= 1'b0; // [RULE23]
              if (!addr_guarded) begin // [RULE14] [RULE25]
                busy <= 1'b1;
                o_erase_valid <= 1'b1;
                o_erase_addr <= addr;
                if (opcode == sfb_pkg::OP_BLOCK_ERASE) begin
                  o_erase_kind <= sfb_pkg::ERASE_BLOCK;
                  timer <= sfb_pkg::sfb_timer_t'(BLOCK_ERASE_CYC); // [RULE21]
                end else begin
                  o_erase_kind <= sfb_pkg::ERASE_SECTOR;
                  timer <= sfb_pkg::sfb_timer_t'(SECTOR_ERASE_CYC); // [RULE21]
                end
              end
            end
          end
          sfb_pkg::OP_CHIP_ERASE, sfb_pkg::OP_CHIP_ERASE_ALT: begin
            if (state == sfb_pkg::ST_SKIP && may_write) begin
              write_enable_latch <= 1'b0; // [RULE23]
              if (level == 3'h0 && !bottom) begin // [RULE26]
                busy <= 1'b1;
                o_erase_valid <= 1'b1;
                o_erase_kind <= sfb_pkg::ERASE_CHIP;
                o_erase_addr <= '0;
                timer <= sfb_pkg::sfb_timer_t'(CHIP_ERASE_CYC); // [RULE21]
              end
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // read data launch after each falling clock edge
  always_ff @(posedge i_clk) begin
    if (i_srst || !selected || state != sfb_pkg::ST_RDATA) begin
      drive_en <= 1'b0; // [RULE27]
      out_cnt <= 3'h0;
      out_byte <= 8'h00;
      o_dual_data_pins <= 2'h0;
    end else if (fall_ok) begin
      drive_en <= 1'b1;
      o_dual_data_pins <= (out_step == 3'h2) ? out_cur[7:6] : {out_cur[7], 1'b0}; // [RULE4] [RULE6]
      out_byte <= out_cur << out_step;
      out_cnt <= 3'(out_cnt + out_step);
    end
  end

  // pin 1 is the serial output; pin 0 drives only in dual reads
  assign o_dual_data_pins_oe = (drive_en && !held) ? (dual_io ? 2'b11 : 2'b10) : 2'b00; // [RULE10] [RULE27]
endmodule

// File: hw/sfb_pkg.sv
// constants, types and the guard decode for the serial flash bus front end
package sfb_pkg;
  // clock rate and busy durations
  localparam int CLK_KHZ = 25000;
  localparam int T_CHIP_ERASE_MS = 250;
  localparam int T_SECTOR_ERASE_MS = 40;
  localparam int T_BLOCK_ERASE_MS = 80;
  localparam int T_PAGE_PROG_MS = 4;
  localparam int CHIP_ERASE_CYC = T_CHIP_ERASE_MS * CLK_KHZ;
  localparam int SECTOR_ERASE_CYC = T_SECTOR_ERASE_MS * CLK_KHZ;
  localparam int BLOCK_ERASE_CYC = T_BLOCK_ERASE_MS * CLK_KHZ;
  localparam int PAGE_PROG_CYC = T_PAGE_PROG_MS * CLK_KHZ;
  localparam int TIMER_W = 23;

  // array geometry
  localparam int ADDR_W = 19;
  localparam int SECTOR_COUNT = 128;
  localparam int SECTOR_BYTES = 4096;
  localparam int BLOCK_COUNT = 8;
  localparam int BLOCK_BYTES = 65536;
  localparam int PAGE_BYTES = 256;
  localparam int BLOCK_LSB = 16;
  localparam logic [1:0] ADDR_LAST = 2'h2;

  // status field positions and power-up values
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_GL0 = 2;
  localparam int ST_GL2 = 4;
  localparam int ST_BOTTOM = 5;
  localparam int ST_LOCK = 7;
  localparam logic [2:0] GUARD_LEVEL_RST = 3'h0;
  localparam logic GUARD_AT_BOTTOM_RST = 1'b0;
  localparam logic GUARD_LOCK_RST = 1'b0;

  // synchroniser reset image: {din, wp_n, hold_n, sck, cs_n}
  localparam logic [5:0] SYNC_RST = 6'h0d;

  // opcodes
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_DUAL_IO_READ = 8'hbb;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_SECTOR_ERASE_ALT = 8'hd7;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_ALT = 8'hc7;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;

  typedef logic [ADDR_W-1:0] sfb_addr_t;
  typedef logic [TIMER_W-1:0] sfb_timer_t;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_OPC   = 7'h02,
    ST_ADDR  = 7'h04,
    ST_DUMMY = 7'h08,
    ST_WDATA = 7'h10,
    ST_RDATA = 7'h20,
    ST_SKIP  = 7'h40
  } sfb_state_t;

  typedef enum logic [1:0] {
    ERASE_SECTOR = 2'h0,
    ERASE_BLOCK  = 2'h1,
    ERASE_CHIP   = 2'h2
  } sfb_erase_t;

  // true when the 64 KB block blk lies in the guarded region
  function automatic logic sfb_guarded(input logic [2:0] level, input logic bottom, input logic [2:0] blk);
    logic [3:0] span;
    case (level)
      3'h1: span = 4'h1;
      3'h2: span = 4'h2;
      3'h3: span = 4'h4;
      default: span = level[2] ? 4'h8 : 4'h0;
    endcase
    if (bottom) begin
      return {1'b0, blk} < span;
    end
    return {1'b0, blk} >= 4'(4'h8 - span);
  endfunction
endpackage

// File: hw/sfb_pins_if.sv
// synchronised pin levels and edge pulses passed from the sampler to the core
`timescale 1ns/1ns
interface sfb_pins_if;
  logic cs_n;
  logic sck;
  logic hold_n;
  logic wp_n;
  logic [1:0] din;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic hold_fall;
  logic hold_rise;
  modport sync (output cs_n, sck, hold_n, wp_n, din, sck_rise, sck_fall, cs_fall, cs_rise, hold_fall, hold_rise);
  modport core (input cs_n, sck, hold_n, wp_n, din, sck_rise, sck_fall, cs_fall, cs_rise, hold_fall, hold_rise);
endinterface

// File: hw/sfb_pin_sync.sv
// two-stage pin synchroniser with edge detection for select, clock and hold
`timescale 1ns/1ns
module sfb_pin_sync (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_hold_n,
  input wire logic i_wp_n,
  input wire logic [1:0] i_din,
  sfb_pins_if.sync pins
);
  logic [5:0] meta;
  logic [5:0] stage;
  logic [2:0] prev;

  // first stage feeds only the second
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta <= sfb_pkg::SYNC_RST;
      stage <= sfb_pkg::SYNC_RST;
    end else begin
      meta <= {i_din, i_wp_n, i_hold_n, i_sck, i_cs_n};
      stage <= meta;
    end
  end

  // previous settled levels for edge finding
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      prev <= sfb_pkg::SYNC_RST[2:0];
    end else begin
      prev <= stage[2:0];
    end
  end

  // the same edges serve whatever idle level the clock keeps
  assign pins.cs_n = stage[0];
  assign pins.sck = stage[1];
  assign pins.hold_n = stage[2];
  assign pins.wp_n = stage[3];
  assign pins.din = stage[5:4];
  assign pins.cs_fall = prev[0] & ~stage[0];
  assign pins.cs_rise = ~prev[0] & stage[0];
  assign pins.sck_rise = ~prev[1] & stage[1]; // [RULE5]
  assign pins.sck_fall = prev[1] & ~stage[1]; // [RULE5]
  assign pins.hold_fall = prev[2] & ~stage[2];
  assign pins.hold_rise = ~prev[2] & stage[2];
endmodule

// File: dv/sfb_front_end_sva.sv
// assertions on the serial flash front end ports
`timescale 1ns/1ns
module sfb_front_end_sva (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_hold_n,
  input wire logic i_wp_n,
  input wire logic [1:0] o_dual_data_pins,
  input wire logic [1:0] o_dual_data_pins_oe,
  input wire logic o_prog_valid,
  input wire logic o_erase_valid,
  input wire logic [1:0] o_erase_kind,
  input wire logic [7:0] o_status
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // protect pin low with lock set, long enough to clear the synchroniser
  sequence locked_s;
    (!i_wp_n && o_status[7])[*4];
  endsequence
  // busy already up with the pulse and still up a cycle on
  sequence busy_s;
    o_status[0] ##1 o_status[0];
  endsequence
  a_deselect_float: assert property (i_cs_n[*5] |-> o_dual_data_pins_oe == 2'h0)
    else $error("output driven while deselected");
  a_hold_float: assert property (!i_hold_n[*5] |-> o_dual_data_pins_oe == 2'h0)
    else $error("output driven while paused");
  a_enable_code: assert property (o_dual_data_pins_oe != 2'h1)
    else $error("illegal output enable pattern");
  a_launch_after_fall: assert property ($changed(o_dual_data_pins) && o_dual_data_pins_oe != 2'h0 |-> !$past(i_sck, 2))
    else $error("output bit changed without a clock fall");
  a_latch_clear_end: assert property ($fell(o_status[1]) |-> i_cs_n)
    else $error("write latch cleared inside a frame");
  a_busy_start_end: assert property ($rose(o_status[0]) |-> i_cs_n)
    else $error("busy started inside a frame");
  a_prog_gated: assert property (o_prog_valid |-> o_status[1] && !o_status[0])
    else $error("program without latch or while busy");
  a_erase_busy: assert property (o_erase_valid |-> busy_s)
    else $error("erase did not raise busy");
  a_chip_unguarded: assert property (o_erase_valid && o_erase_kind == 2'h2 |-> o_status[5:2] == 4'h0)
    else $error("chip erase with guard bits set");
  a_guard_frozen: assert property (locked_s |=> $stable(o_status[7:2]))
    else $error("guard bits changed while locked");
endmodule
bind sfb_front_end sfb_front_end_sva i_sfb_front_end_sva (
  .i_clk(i_clk), .i_srst(i_srst), .i_cs_n(i_cs_n), .i_sck(i_sck), .i_hold_n(i_hold_n), .i_wp_n(i_wp_n),
  .o_dual_data_pins(o_dual_data_pins), .o_dual_data_pins_oe(o_dual_data_pins_oe), .o_prog_valid(o_prog_valid),
  .o_erase_valid(o_erase_valid), .o_erase_kind(o_erase_kind), .o_status(o_status));

// File: dv/sfb_host_model.sv
// serial bus host that drives select, clock, hold and data pins
`timescale 1ns/1ns
module sfb_host_model (
  input wire logic i_clk,
  input wire logic [1:0] i_pins,
  output logic o_cs_n,
  output logic o_sck,
  output logic o_hold_n,
  output logic [1:0] o_data
);
  logic mode3 = 1'b0;
  logic abort = 1'b0;
  int hold_at = -1;
  // idle pins: deselected, clock low, hold released
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_hold_n = 1'b1;
    o_data = 2'h0;
  end
  // half a serial clock period, 160 ns
  task automatic half();
    repeat (4) @(negedge i_clk);
  endtask
  // clock parked at the mode idle level before select falls
  task automatic open_frame();
    o_sck = mode3;
    half();
    o_cs_n = 1'b0;
    half();
  endtask
  // select rises only after the last bit of the sequence
  task automatic close_frame();
    if (!mode3) o_sck = 1'b0;
    half();
    o_cs_n = 1'b1;
    o_data = ~o_data;
    half();
  endtask
  // one byte, eight single or four dual bit times, data set while clock is low
  task automatic xfer(input logic [7:0] tx, input logic two, output logic [7:0] rx);
    int n;
    n = two ? 4 : 8;
    for (int i = 0; i < n; i++) begin
      o_sck = 1'b0;
      if (two) o_data = tx[7-2*i -: 2];
      else o_data = {~o_data[1], tx[7-i]};
      half();
      if (i == hold_at) begin
        o_hold_n = 1'b0;
        half();
        o_sck = 1'b1;
        o_data = ~o_data;
        half();
        o_sck = 1'b0;
        half();
        hold_at = -1;
        if (abort) begin
          o_cs_n = 1'b1;
          half();
          o_hold_n = 1'b1;
          return;
        end
        o_data = two ? tx[7-2*i -: 2] : {o_data[1], tx[7-i]};
        o_hold_n = 1'b1;
        half();
      end
      o_sck = 1'b1;
      rx = two ? {rx[5:0], i_pins} : {rx[6:0], i_pins[1]};
      half();
    end
  endtask
endmodule

// File: dv/sfb_front_end_bench.sv
// self-checking bench for the serial flash front end
`timescale 1ns/1ns
module sfb_front_end_bench;
  localparam int PP = 60;
  localparam int SE = 80;
  localparam int BE = 100;
  localparam int CE = 120;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_wp_n = 1'b1;
  logic cs_n, sck, hold_n, prog_v, erase_v;
  logic [1:0] hd, pins, dout, oe, ekind;
  logic [7:0] rdata, pdata, status, rx;
  logic [18:0] raddr, paddr, eaddr;
  logic [39:0] ops[3] = '{40'h20023000, 40'hd8020000, 40'h60};
  logic [18:0] eadr[3] = '{19'h23000, 19'h20000, 19'h0};
  int lens[3] = '{SE, BE, CE};
  int err_count = 0;
  int total_checks = 0;
  int prog_cnt = 0;
  int erase_cnt = 0;
  int busy_len = 0;
  // wire level: design where enabled, host elsewhere
  assign pins = (oe & dout) | (~oe & hd);
  // array image seen by reads
  assign rdata = raddr[7:0] ^ 8'h3c;
  initial begin
    forever #20 i_clk = ~i_clk;
  end
  // count array pulses and busy cycles
  always @(posedge i_clk) begin
    if (prog_v) prog_cnt++;
    if (erase_v) erase_cnt++;
    if (status[0]) busy_len++;
  end
  sfb_front_end #(.CHIP_ERASE_CYC(CE), .SECTOR_ERASE_CYC(SE), .BLOCK_ERASE_CYC(BE), .PAGE_PROG_CYC(PP)) i_sfb_front_end (
    .i_clk(i_clk), .i_srst(i_srst), .i_cs_n(cs_n), .i_sck(sck), .i_hold_n(hold_n), .i_wp_n(i_wp_n),
    .i_dual_data_pins(pins), .o_dual_data_pins(dout), .o_dual_data_pins_oe(oe), .o_read_addr(raddr),
    .i_read_data(rdata), .o_prog_valid(prog_v), .o_prog_addr(paddr), .o_prog_data(pdata),
    .o_erase_valid(erase_v), .o_erase_kind(ekind), .o_erase_addr(eaddr), .o_status(status));
  sfb_host_model i_sfb_host_model (.i_clk(i_clk), .i_pins(pins), .o_cs_n(cs_n), .o_sck(sck), .o_hold_n(hold_n),
    .o_data(hd));
  // compare a design value
  task automatic cmpv(input logic [18:0] got, input logic [18:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // compare a count of events
  task automatic cmpn(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      err_count++;
      $display("unexpected count at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one framed command of n bytes, most significant byte first
  task automatic frame(input logic [39:0] v, input int n);
    i_sfb_host_model.open_frame();
    for (int i = n - 1; i >= 0; i--) i_sfb_host_model.xfer(v[8*i +: 8], 1'b0, rx);
    i_sfb_host_model.close_frame();
  endtask
  // enable writes then write the status byte
  task automatic wstat(input logic [7:0] s);
    frame(40'h06, 1);
    frame({24'h0, 8'h01, s}, 2);
  endtask
  // read the status byte once
  task automatic rdstat(input logic [7:0] exp);
    i_sfb_host_model.open_frame();
    i_sfb_host_model.xfer(8'h05, 1'b0, rx);
    i_sfb_host_model.xfer(8'h00, 1'b0, rx);
    i_sfb_host_model.close_frame();
    cmpv(19'(rx), 19'(exp));
  endtask
  // array read from 0x00140, two bytes, single or dual
  task automatic rd(input logic two);
    i_sfb_host_model.open_frame();
    i_sfb_host_model.xfer(two ? 8'hbb : 8'h03, 1'b0, rx);
    i_sfb_host_model.xfer(8'h00, two, rx);
    i_sfb_host_model.xfer(8'h01, two, rx);
    i_sfb_host_model.xfer(8'h40, two, rx);
    if (two) i_sfb_host_model.xfer(8'h00, two, rx);
    i_sfb_host_model.hold_at = 2;
    i_sfb_host_model.xfer(8'h00, two, rx);
    cmpv(19'(rx), 19'h7c);
    i_sfb_host_model.xfer(8'h00, two, rx);
    cmpv(19'(rx), 19'h7d);
    i_sfb_host_model.close_frame();
  endtask
  // print counts and verdict, then end the run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (60000) @(posedge i_clk);
    err_count++;
    stop_test();
  end
  // main sequence
  initial begin
    repeat (20) @(negedge i_clk);
    i_srst = 1'b0;
    repeat (3) @(negedge i_clk);
    cmpv(19'(status), 19'h0);
    cmpv(19'(oe), 19'h0);
    $display("test reset done");
    frame(40'h06, 1);
    cmpv(19'(status), 19'h02);
    i_sfb_host_model.mode3 = 1'b1;
    i_sfb_host_model.hold_at = 3;
    rdstat(8'h02);
    i_sfb_host_model.mode3 = 1'b0;
    frame(40'h04, 1);
    cmpv(19'(status), 19'h0);
    i_sfb_host_model.hold_at = 5;
    i_sfb_host_model.abort = 1'b1;
    frame(40'h06, 1);
    i_sfb_host_model.abort = 1'b0;
    cmpv(19'(status), 19'h0);
    $display("test framing and hold done");
    wstat(8'hac);
    cmpv(19'(status), 19'hac);
    i_wp_n = 1'b0;
    wstat(8'h00);
    cmpv(19'(status), 19'hac);
    i_wp_n = 1'b1;
    wstat(8'h04);
    rdstat(8'h04);
    $display("test status protection done");
    busy_len = 0;
    frame(40'h06, 1);
    frame(40'h0207001055, 5);
    cmpn(prog_cnt, 0);
    frame(40'h06, 1);
    frame(40'h02010020a5, 5);
    repeat (PP + 20) @(negedge i_clk);
    cmpn(prog_cnt, 1);
    cmpv(paddr, 19'h10020);
    cmpv(19'(pdata), 19'ha5);
    cmpn(busy_len, PP);
    cmpv(19'(status), 19'h04);
    $display("test program done");
    frame(40'h06, 1);
    frame(40'h60, 1);
    cmpn(erase_cnt, 0);
    wstat(8'h00);
    for (int k = 0; k < 3; k++) begin
      busy_len = 0;
      frame(40'h06, 1);
      frame(ops[k], k == 2 ? 1 : 4);
      repeat (CE + 20) @(negedge i_clk);
      cmpn(erase_cnt, k + 1);
      cmpv(19'(ekind), 19'(k));
      cmpv(eaddr, eadr[k]);
      cmpn(busy_len, lens[k]);
    end
    $display("test erase done");
    rd(1'b0);
    rd(1'b1);
    $display("test reads done");
    stop_test();
  end
endmodule
